/* File: core/pcem_pkg.sv */
// Purpose: constants for the shared analogue port read multiplexer
// Assumes: 32-bit apb, one aligned word per register
// Notes:   offsets are byte addresses
package pcem_pkg;
    localparam int unsigned PCEM_WIDTH      = 4;
    localparam logic [7:0]  PCEM_DIR_OFS    = 8'h04;
    localparam logic [7:0]  PCEM_DATA_OFS   = 8'h10;
    localparam logic [7:0]  PCEM_PIN_OFS    = 8'h14;
    localparam logic [7:0]  PCEM_MODE_OFS   = 8'h18;
    localparam logic [3:0]  PCEM_DIR_RST    = 4'h0;
    localparam logic [3:0]  PCEM_DATA_RST   = 4'h0;
    localparam int unsigned PCEM_MODE_CMP1  = 0;
    localparam int unsigned PCEM_MODE_CMP2  = 1;
    localparam int unsigned PCEM_MODE_AMP   = 2;
    localparam int unsigned PCEM_MODE_B1ZERO = 3;
    localparam int unsigned PCEM_MODE_B3ZERO = 4;
    localparam int unsigned PCEM_MODE_GAIN  = 5;
    localparam int unsigned PCEM_MODE_BIDIR = 6;
endpackage

/* File: core/pcem_port.sv */
// Purpose: 4-bit shared port with comparator/amplifier read multiplexer
// Assumes: option inputs are static straps, apb slave, zero wait states
// Notes:   pin inputs pass four flops before use
//
// Operation
// - all options off: input-only port, direction writes ignored, normal reads on all bits
// - comparator two only, bit3 zero off: bit 3 reads the pin
// - comparator two only: bit 2 reads comparator two output
// - comparator two only, bit3 zero on: bit 3 reads 0
// - combined mode: bits 2 and 3 read 0
// - combined mode, bit1 zero off: bit 1 reads the pin
// - combined mode: bit 0 reads comparator one output
// - combined mode, bit1 zero on: bit 1 reads 0
// - comparator one only: bit 0 comparator, bit 1 pin or 0
// - direction bit 1 selects output, 0 selects input
`timescale 1ns/1ps
module pcem_port
    import pcem_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   comparator_one_option,
    input  wire logic                   comparator_two_option,
    input  wire logic                   amp_option,
    input  wire logic                   bit1_read_zero_option,
    input  wire logic                   bit3_read_zero_option,
    input  wire logic                   gain_stage_enable,
    input  wire logic                   shared_port_bidir_option,
    input  wire logic [PCEM_WIDTH-1:0]  shared_pin_in,
    input  wire logic                   cmp_one_out,
    input  wire logic                   cmp_two_out,
    output logic      [PCEM_WIDTH-1:0]  shared_pin_out,
    output logic      [PCEM_WIDTH-1:0]  shared_pin_oe_n
);
    import pcem_pkg::*;

    logic [PCEM_WIDTH-1:0] sync1_r, sync2_r, sync3_r, pin_r;
    logic [PCEM_WIDTH-1:0] pin_nxt;
    logic                  cmp1_s1_r, cmp1_s2_r, cmp1_s3_r, cmp1_r, cmp1_nxt;
    logic                  cmp2_s1_r, cmp2_s2_r, cmp2_s3_r, cmp2_r, cmp2_nxt;
    logic [6:0]            mode_r, mode_nxt;
    logic                  captured_r, captured_nxt;
    logic [PCEM_WIDTH-1:0] shared_port_direction_r, dir_nxt;
    logic [PCEM_WIDTH-1:0] shared_port_data_r, data_nxt;
    logic [31:0]           prdata_nxt;
    logic                  pready_nxt, pslverr_nxt;
    logic [PCEM_WIDTH-1:0] normal_rd, mux_rd;
    logic                  cmp1_on, cmp2_on, amp_on, b1_zero, b3_zero, bidir;
    logic                  combined, two_only, one_only;
    logic                  wr_en;

    // input synchronisers: change accepted when stages two and three agree
    always_comb begin
        pin_nxt  = pin_r;
        cmp1_nxt = cmp1_r;
        cmp2_nxt = cmp2_r;
        for (int i = 0; i < PCEM_WIDTH; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
                pin_nxt[i] = sync3_r[i];
            end
        end
        if (cmp1_s2_r == cmp1_s3_r) begin
            cmp1_nxt = cmp1_s3_r;
        end
        if (cmp2_s2_r == cmp2_s3_r) begin
            cmp2_nxt = cmp2_s3_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r   <= '0;
            sync2_r   <= '0;
            sync3_r   <= '0;
            pin_r     <= '0;
            cmp1_s1_r <= 1'b0;
            cmp1_s2_r <= 1'b0;
            cmp1_s3_r <= 1'b0;
            cmp1_r    <= 1'b0;
            cmp2_s1_r <= 1'b0;
            cmp2_s2_r <= 1'b0;
            cmp2_s3_r <= 1'b0;
            cmp2_r    <= 1'b0;
        end else begin
            sync1_r   <= shared_pin_in;
            sync2_r   <= sync1_r;
            sync3_r   <= sync2_r;
            pin_r     <= pin_nxt;
            cmp1_s1_r <= cmp_one_out;
            cmp1_s2_r <= cmp1_s1_r;
            cmp1_s3_r <= cmp1_s2_r;
            cmp1_r    <= cmp1_nxt;
            cmp2_s1_r <= cmp_two_out;
            cmp2_s2_r <= cmp2_s1_r;
            cmp2_s3_r <= cmp2_s2_r;
            cmp2_r    <= cmp2_nxt;
        end
    end

    // option straps captured on the first edge after reset release
    always_comb begin
        mode_nxt     = mode_r;
        captured_nxt = 1'b1;
        if (!captured_r) begin
            mode_nxt = {shared_port_bidir_option, gain_stage_enable,
                        bit3_read_zero_option, bit1_read_zero_option,
                        amp_option, comparator_two_option, comparator_one_option};
        end
    end

    assign cmp1_on  = mode_r[PCEM_MODE_CMP1];
    assign cmp2_on  = mode_r[PCEM_MODE_CMP2];
    assign amp_on   = mode_r[PCEM_MODE_AMP];
    assign b1_zero  = mode_r[PCEM_MODE_B1ZERO];
    assign b3_zero  = mode_r[PCEM_MODE_B3ZERO];
    assign bidir    = mode_r[PCEM_MODE_BIDIR];
    // combined mode only with comparator two off
    assign combined = cmp1_on && amp_on && !cmp2_on;
    assign two_only = cmp2_on && !cmp1_on && !amp_on;
    assign one_only = cmp1_on && !cmp2_on && !amp_on;

    // ordinary read: pin for inputs, latch for outputs
    always_comb begin
        for (int i = 0; i < PCEM_WIDTH; i++) begin
            normal_rd[i] = shared_port_direction_r[i] ? shared_port_data_r[i] : pin_r[i];
        end
    end

    always_comb begin
        mux_rd = normal_rd;
        if (combined) begin
            mux_rd[3] = 1'b0;
            mux_rd[2] = 1'b0;
            mux_rd[1] = b1_zero ? 1'b0 : pin_r[1];
            mux_rd[0] = cmp1_r;
        end else if (two_only) begin
            mux_rd[3] = b3_zero ? 1'b0 : pin_r[3];
            mux_rd[2] = cmp2_r;
        end else if (one_only) begin
            mux_rd[1] = b1_zero ? 1'b0 : pin_r[1];
            mux_rd[0] = cmp1_r;
        end
    end

    // apb slave, one access cycle, no wait states
    assign wr_en = psel && penable && pwrite;

    always_comb begin
        dir_nxt     = shared_port_direction_r;
        data_nxt    = shared_port_data_r;
        prdata_nxt  = prdata;
        pready_nxt  = psel && !penable;
        pslverr_nxt = 1'b0;
        if (wr_en) begin
            if (paddr == PCEM_DIR_OFS) begin
                if (bidir) begin
                    dir_nxt = pwdata[PCEM_WIDTH-1:0];
                end
            end else if (paddr == PCEM_DATA_OFS) begin
                data_nxt = pwdata[PCEM_WIDTH-1:0];
            end
        end
        if (psel && !penable) begin
            prdata_nxt = '0;
            if (paddr == PCEM_DIR_OFS) begin
                prdata_nxt[PCEM_WIDTH-1:0] = shared_port_direction_r;
            end else if (paddr == PCEM_DATA_OFS) begin
                prdata_nxt[PCEM_WIDTH-1:0] = mux_rd;
            end else if (paddr == PCEM_PIN_OFS) begin
                prdata_nxt[PCEM_WIDTH-1:0] = pin_r;
            end else if (paddr == PCEM_MODE_OFS) begin
                prdata_nxt[6:0] = mode_r;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r                  <= '0;
            captured_r              <= 1'b0;
            shared_port_direction_r <= PCEM_DIR_RST;
            shared_port_data_r      <= PCEM_DATA_RST;
            prdata                  <= '0;
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
            shared_pin_out          <= '0;
            shared_pin_oe_n         <= '1;
        end else begin
            mode_r                  <= mode_nxt;
            captured_r              <= captured_nxt;
            shared_port_direction_r <= dir_nxt;
            shared_port_data_r      <= data_nxt;
            prdata                  <= prdata_nxt;
            pready                  <= pready_nxt;
            pslverr                 <= pslverr_nxt;
            shared_pin_out          <= data_nxt;
            shared_pin_oe_n         <= ~dir_nxt;
        end
    end

    chk_combined_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
        combined |-> mux_rd[3:2] == 2'b00) else $error("combined mode bits 3..2 not zero");
    chk_combined_bit0_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        combined |-> mux_rd[0] == cmp1_r) else $error("combined bit 0 not comparator one");
    chk_combined_bit1: assert property (@(posedge pclk) disable iff (!presetn)
        combined && b1_zero |-> !mux_rd[1]) else $error("combined bit 1 not zero");
    chk_combined_bit1_pin: assert property (@(posedge pclk) disable iff (!presetn)
        combined && !b1_zero |-> mux_rd[1] == pin_r[1]) else $error("combined bit 1 not pin");
    chk_two_bit2_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        two_only |-> mux_rd[2] == cmp2_r) else $error("bit 2 not comparator two");
    chk_two_bit3_zero: assert property (@(posedge pclk) disable iff (!presetn)
        two_only && b3_zero |-> !mux_rd[3]) else $error("bit 3 not zero");
    chk_two_bit3_pin: assert property (@(posedge pclk) disable iff (!presetn)
        two_only && !b3_zero |-> mux_rd[3] == pin_r[3]) else $error("bit 3 not pin");
    chk_plain_read: assert property (@(posedge pclk) disable iff (!presetn)
        !cmp1_on && !cmp2_on && !amp_on |-> mux_rd == normal_rd) else $error("plain read wrong");
    chk_one_bit0_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        one_only |-> mux_rd[0] == cmp1_r) else $error("bit 0 not comparator one");
    chk_one_bit1_zero: assert property (@(posedge pclk) disable iff (!presetn)
        one_only && b1_zero |-> !mux_rd[1]) else $error("bit 1 not zero");
    chk_mode_static: assert property (@(posedge pclk) disable iff (!presetn)
        captured_r |=> $stable(mode_r)) else $error("mode changed after capture");
    chk_dir_oe: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == PCEM_DIR_OFS && bidir |=> shared_pin_oe_n == ~$past(pwdata[3:0]))
        else $error("direction write not applied");
endmodule

/* File: verification/pcem_pin_model.sv */
// Purpose: pins and comparators outside the shared port
// Assumes: released pins show the outside level
// Notes:   comparator levels come straight from the bench
`timescale 1ns/1ps
module pcem_pin_model
    import pcem_pkg::*;
(
    input  wire logic [PCEM_WIDTH-1:0] ext_level,
    input  wire logic [PCEM_WIDTH-1:0] pin_out,
    input  wire logic [PCEM_WIDTH-1:0] pin_oe_n,
    input  wire logic                  cmp_one_src,
    input  wire logic                  cmp_two_src,
    output logic      [PCEM_WIDTH-1:0] pin_level,
    output logic                       cmp_one,
    output logic                       cmp_two
);
    // driven pins follow the latch
    always_comb begin
        for (int i = 0; i < PCEM_WIDTH; i++) begin
            pin_level[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
        end
    end
    assign cmp_one = cmp_one_src;
    assign cmp_two = cmp_two_src;
endmodule

/* File: verification/port_ce_analog_read_mux_test.sv */
// Purpose: bench for the shared port read multiplexer
// Assumes: straps other than gain_stage_enable are inverted after capture and must be ignored until reset
// Notes:   expected reads worked out from the mode tables
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module port_ce_analog_read_mux_test;
    import pcem_pkg::*;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic [6:0]  st = '0;
    logic [3:0]  ext = '0;
    logic [3:0]  lvl;
    logic [3:0]  pout;
    logic [3:0]  oe_n;
    logic        c1 = 0;
    logic        c2 = 0;
    logic        c1o;
    logic        c2o;
    int          num_errors = 0;
    int          tests_run = 0;
    logic [6:0]  modes [8] = '{7'h00, 7'h01, 7'h09, 7'h02, 7'h12, 7'h05, 7'h0d, 7'h03};
    always #5 pclk = ~pclk;
    pcem_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_one_option(st[0]), .comparator_two_option(st[1]),
        .amp_option(st[2]), .bit1_read_zero_option(st[3]), .bit3_read_zero_option(st[4]),
        .gain_stage_enable(st[5]), .shared_port_bidir_option(st[6]), .shared_pin_in(lvl),
        .cmp_one_out(c1o), .cmp_two_out(c2o), .shared_pin_out(pout), .shared_pin_oe_n(oe_n));
    pcem_pin_model pins_u (.ext_level(ext), .pin_out(pout), .pin_oe_n(oe_n),
        .cmp_one_src(c1), .cmp_two_src(c2), .pin_level(lvl), .cmp_one(c1o), .cmp_two(c2o));
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) begin
            num_errors++;
            conclude();
        end else begin
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic restart(input logic [6:0] s);
        presetn <= 1'b0;
        st      <= s;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    function automatic logic [3:0] exp_rd(logic [6:0] s, logic [3:0] pin, logic a, logic b);
        logic [3:0] v;
        v = pin;
        if (s[0] && s[2] && !s[1]) v = {2'b00, s[3] ? 1'b0 : pin[1], a};
        else if (s[0] && !s[1] && !s[2]) v[1:0] = {s[3] ? 1'b0 : pin[1], a};
        else if (s[1] && !s[0] && !s[2]) v[3:2] = {s[4] ? 1'b0 : pin[3], b};
        return v;
    endfunction
    initial begin
        repeat (12) @(posedge pclk);
        foreach (modes[m]) begin
            restart(modes[m]);
            st <= ~modes[m] & 7'h5f;
            apb(1'b0, PCEM_MODE_OFS, '0);
            `CHK("straps", {25'h0, modes[m]}, rd)
            for (int p = 0; p < 2; p++) begin
                ext <= p ? 4'h5 : 4'ha;
                c1  <= !p;
                c2  <= p;
                repeat (8) @(posedge pclk);
                apb(1'b0, PCEM_DATA_OFS, '0);
                `CHK("port", {28'h0, exp_rd(modes[m], ext, c1, c2)}, rd)
            end
            $display("mode %h done", modes[m]);
        end
        restart(7'h40);
        ext <= 4'hf;
        apb(1'b1, PCEM_DIR_OFS, 32'h6);
        apb(1'b1, PCEM_DATA_OFS, 32'hf4);
        repeat (8) @(posedge pclk);
        `CHK("oe_n", 4'h9, oe_n)
        `CHK("pin out", 4'h4, pout)
        apb(1'b0, PCEM_DATA_OFS, '0);
        `CHK("mixed read", 32'hd, rd)
        restart(7'h00);
        apb(1'b1, PCEM_DIR_OFS, 32'hf);
        apb(1'b0, PCEM_DIR_OFS, '0);
        `CHK("dir locked", 32'h0, rd)
        apb(1'b0, 8'h08, '0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        $display("direction and bus tests done");
        conclude();
    end
endmodule
